// [rtl/cir_irq_regs.sv]
// Interrupt enable mask, pending flags, interrupt pin and source code.
// Assumes event strobes and condition levels come from logic on sys_clk,
// and register requests arrive from the SPI command decoder on sys_clk.
`timescale 1ns/10ps

// How it works
// - Mask bit 7 gates message error events onto the interrupt.
// - Mask bit 6 gates bus activity wakeup onto the interrupt.
// - Mask bit 5 gates error condition changes onto the interrupt.
// - Mask bits 4,3,2 gate transmit buffer 2,1,0 empty events.
// - Mask bits 1,0 gate receive buffer 1,0 full events.
// - Mask register is read/write, all eight bits, resets to zero.
// - Flag reads 1 while pending; host clears it to drop the interrupt.
// - Flag bits 7,6,5 hold message error, wakeup, error change pending.
// - Flag bits 4,3,2 hold transmit buffer 2,1,0 empty pending.
// - Flag bits 1,0 hold receive buffer 1,0 full pending.
// - Flag register is read/write, all eight bits, resets to zero.
// - Interrupt pin low while any enabled flag is pending.
// - Host setting a flag raises the interrupt when enabled.
// - Clearing a flag is refused while its condition persists.
// - Source code reports highest priority enabled pending source other than message error, 0 if none.
module cir_irq_regs
  import cir_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire cir_reg_req_t reg_req,
  output logic [7:0]        reg_rdata_ff,
  output logic              reg_rvalid_ff,
  input  wire logic [7:0]   src_event,
  input  wire logic [7:0]   src_active,
  output logic              irq_n_ff,
  output logic [2:0]        pending_source_code_ff,
  output logic [7:0]        interrupt_enable_mask_ff,
  output logic [7:0]        interrupt_pending_flags_ff
);

  logic [7:0] nxt_flags;
  logic [7:0] nxt_mask;
  logic [7:0] enabled_pending;
  logic [2:0] nxt_code;
  logic       hit_mask;
  logic       hit_flags;

  // Shared decode for write and read paths
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : addr_hit

  assign hit_mask  = addr_hit(reg_req.addr, CIR_OFS_IRQ_EN);
  assign hit_flags = addr_hit(reg_req.addr, CIR_OFS_IRQ_FLAGS);

  // Mask write honours the bit-modify mask; full write uses all ones
  always_comb begin
    nxt_mask = interrupt_enable_mask_ff;
    if (reg_req.wr && hit_mask) begin
      nxt_mask = (interrupt_enable_mask_ff & ~reg_req.wmask)
               | (reg_req.wdata & reg_req.wmask);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      interrupt_enable_mask_ff <= CIR_EN_RST;
    end else begin
      interrupt_enable_mask_ff <= nxt_mask;
    end
  end

  // Flags: host write first, then held conditions and new events override.
  // Event wins over a clear in the same cycle, so no interrupt is lost.
  always_comb begin
    nxt_flags = interrupt_pending_flags_ff;
    if (reg_req.wr && hit_flags) begin
      nxt_flags = (interrupt_pending_flags_ff & ~reg_req.wmask)
                | (reg_req.wdata & reg_req.wmask);
    end
    // Clear refused while the source condition still holds
    nxt_flags = nxt_flags | (interrupt_pending_flags_ff & src_active);
    // Set on event whatever the mask holds
    nxt_flags = nxt_flags | src_event;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      interrupt_pending_flags_ff <= CIR_FLAGS_RST;
    end else begin
      interrupt_pending_flags_ff <= nxt_flags;
    end
  end

  // Mask gates only pin and code, from the next flag value so both track
  assign enabled_pending = nxt_flags & nxt_mask;

  always_comb begin
    nxt_code = CIR_CODE_NONE;
    if (enabled_pending[CIR_BIT_ERR_CHG]) begin
      nxt_code = CIR_CODE_ERR;
    end else if (enabled_pending[CIR_BIT_WAKEUP]) begin
      nxt_code = CIR_CODE_WAKEUP;
    end else if (enabled_pending[CIR_BIT_TXBUF0]) begin
      nxt_code = CIR_CODE_TX0;
    end else if (enabled_pending[CIR_BIT_TXBUF1]) begin
      nxt_code = CIR_CODE_TX1;
    end else if (enabled_pending[CIR_BIT_TXBUF2]) begin
      nxt_code = CIR_CODE_TX2;
    end else if (enabled_pending[CIR_BIT_RXBUF0]) begin
      nxt_code = CIR_CODE_RX0;
    end else if (enabled_pending[CIR_BIT_RXBUF1]) begin
      nxt_code = CIR_CODE_RX1;
    end
  end

  // Message error drives the pin but has no code of its own
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_n_ff               <= 1'b1;
      pending_source_code_ff <= CIR_CODE_NONE;
    end else begin
      irq_n_ff               <= ~(|enabled_pending);
      pending_source_code_ff <= nxt_code;
    end
  end

  // Read returns the registered value one cycle later; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata_ff  <= 8'h00;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_req.rd;
      if (reg_req.rd && hit_mask) begin
        reg_rdata_ff <= interrupt_enable_mask_ff;
      end else if (reg_req.rd && hit_flags) begin
        reg_rdata_ff <= interrupt_pending_flags_ff;
      end else begin
        reg_rdata_ff <= 8'h00;
      end
    end
  end

endmodule : cir_irq_regs

// [rtl/cir_pkg.sv]
// Constants and types for the CAN controller interrupt enable and flag block.
// Assumes an internal register access port driven by the SPI command decoder.
package cir_pkg;

  localparam int          CIR_ADDR_W        = 8;
  localparam int          CIR_DATA_W        = 8;
  localparam logic [7:0]  CIR_OFS_IRQ_EN    = 8'h2B;
  localparam logic [7:0]  CIR_OFS_IRQ_FLAGS = 8'h2C;
  localparam logic [7:0]  CIR_EN_RST        = 8'h00;
  localparam logic [7:0]  CIR_FLAGS_RST     = 8'h00;

  // Bit positions shared by mask and flag registers
  localparam int CIR_BIT_MSG_ERR  = 7;
  localparam int CIR_BIT_WAKEUP   = 6;
  localparam int CIR_BIT_ERR_CHG  = 5;
  localparam int CIR_BIT_TXBUF2   = 4;
  localparam int CIR_BIT_TXBUF1   = 3;
  localparam int CIR_BIT_TXBUF0   = 2;
  localparam int CIR_BIT_RXBUF1   = 1;
  localparam int CIR_BIT_RXBUF0   = 0;

  // Pending source codes, lower value wins
  localparam logic [2:0] CIR_CODE_NONE   = 3'h0;
  localparam logic [2:0] CIR_CODE_ERR    = 3'h1;
  localparam logic [2:0] CIR_CODE_WAKEUP = 3'h2;
  localparam logic [2:0] CIR_CODE_TX0    = 3'h3;
  localparam logic [2:0] CIR_CODE_TX1    = 3'h4;
  localparam logic [2:0] CIR_CODE_TX2    = 3'h5;
  localparam logic [2:0] CIR_CODE_RX0    = 3'h6;
  localparam logic [2:0] CIR_CODE_RX1    = 3'h7;

  // Register access request from the SPI command layer
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } cir_reg_req_t;

endpackage : cir_pkg

// [bench/cir_chk_assertions.sv]
// Checker on the interrupt block ports.
// Assumes it is bound into cir_irq_regs.
`timescale 1ns/10ps
module cir_chk
  import cir_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rst_n,
  input wire cir_reg_req_t reg_req,
  input wire logic [7:0]   reg_rdata_ff,
  input wire logic         reg_rvalid_ff,
  input wire logic [7:0]   src_event,
  input wire logic [7:0]   src_active,
  input wire logic         irq_n_ff,
  input wire logic [2:0]   pending_source_code_ff,
  input wire logic [7:0]   interrupt_enable_mask_ff,
  input wire logic [7:0]   interrupt_pending_flags_ff
);
  wire [7:0] m = interrupt_enable_mask_ff;
  wire [7:0] f = interrupt_pending_flags_ff;
  wire [2:0] c = pending_source_code_ff;
  wire       wm = reg_req.wr && reg_req.addr == CIR_OFS_IRQ_EN && &reg_req.wmask;
  wire       rf = reg_req.rd && reg_req.addr == CIR_OFS_IRQ_FLAGS;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  rst_zero_a: assert property ($rose(rst_n) |-> m == 8'h00 && f == 8'h00 && irq_n_ff)
    else $error("bad reset values");
  mask_write_a: assert property (wm |=> m == $past(reg_req.wdata))
    else $error("mask write lost");
  flag_read_a: assert property (rf |=> reg_rvalid_ff && reg_rdata_ff == $past(f))
    else $error("flag read wrong");
  event_sets_a: assert property (|src_event |=> (f & $past(src_event)) == $past(src_event))
    else $error("event flag not set");
  irq_level_a: assert property (irq_n_ff == !(|(m & f)))
    else $error("irq pin wrong");
  clear_block_a: assert property (|(f & src_active) |=> &(f | ~$past(f & src_active)))
    else $error("flag cleared too early");
  code_none_a: assert property ((m & f & 8'h7F) == 8'h00 |-> c == CIR_CODE_NONE)
    else $error("code not none");
  code_err_a: assert property (m[5] && f[5] |-> c == CIR_CODE_ERR)
    else $error("code not error");
  cover property (!irq_n_ff);
  cover property (|(f & src_active));
  cover property (c == CIR_CODE_TX2);
endmodule : cir_chk
bind cir_irq_regs cir_chk chk (.*);

// [bench/cir_host.sv]
// Host model issuing register requests.
// Assumes the block samples requests on the rising edge.
`timescale 1ns/10ps
module cir_host
  import cir_pkg::*;
(
  input  wire logic [7:0] rdata,
  input  wire logic       sys_clk,
  output cir_reg_req_t    req
);
  initial req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, d, k, output logic [7:0] q);
    @(negedge sys_clk) req = '{w, !w, a, d, k};
    @(negedge sys_clk) q = rdata;
    // Released addr, data and mask lines show the inverse, never a stale value; wr and rd go low
    req = '{1'b0, 1'b0, ~a, ~d, ~k};
  endtask : xfer
endmodule : cir_host

// [bench/cir_irq_regs_tb.sv]
// Bench: host accesses and source events against the interrupt block.
// Assumes host model and checker are compiled first.
`timescale 1ns/10ps
module cir_irq_regs_tb
  import cir_pkg::*;
;
  logic         sys_clk = 1'b0, rst_n = 1'b0, irq_n;
  logic [7:0]   ev = 8'h00, act = 8'h00, rdata, flg, q;
  logic [2:0]   code;
  cir_reg_req_t req;
  int           err_count = 0, checks_done = 0, cyc = 0;
  always #4 sys_clk = ~sys_clk;
  cir_host host (.rdata(rdata), .sys_clk(sys_clk), .req(req));
  cir_irq_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(req), .reg_rdata_ff(rdata),
    .reg_rvalid_ff(), .src_event(ev), .src_active(act), .irq_n_ff(irq_n),
    .pending_source_code_ff(code), .interrupt_enable_mask_ff(),
    .interrupt_pending_flags_ff(flg));
  task automatic chk(input logic [7:0] g, e);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask : chk
  task automatic final_report;
    $display("mismatches %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic wr(input logic [7:0] a, d, k);
    host.xfer(1'b1, a, d, k, q);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 8'h00, 8'h00, q);
  endtask : rd
  task automatic pulse(input logic [7:0] b);
    @(negedge sys_clk) ev = b;
    @(negedge sys_clk) ev = 8'h00;
  endtask : pulse
  task automatic t_regs;
    rd(CIR_OFS_IRQ_EN);
    chk(q, CIR_EN_RST);
    wr(CIR_OFS_IRQ_EN, 8'hA5, 8'hFF);
    rd(CIR_OFS_IRQ_EN);
    chk(q, 8'hA5);
    rd(8'h2D);
    chk(q, 8'h00);
  endtask : t_regs
  task automatic t_each;
    logic [2:0] cd [8] = '{CIR_CODE_RX0, CIR_CODE_RX1, CIR_CODE_TX0, CIR_CODE_TX1,
      CIR_CODE_TX2, CIR_CODE_ERR, CIR_CODE_WAKEUP, CIR_CODE_NONE};
    for (int i = 0; i < 8; i++) begin
      wr(CIR_OFS_IRQ_EN, 8'h01 << i, 8'hFF);
      pulse(8'h01 << i);
      chk(flg, 8'h01 << i);
      chk(8'(irq_n), 8'h00);
      chk(8'(code), 8'(cd[i]));
      wr(CIR_OFS_IRQ_FLAGS, 8'h00, 8'h01 << i);
      chk(8'(irq_n), 8'h01);
    end
  endtask : t_each
  task automatic t_mix;
    wr(CIR_OFS_IRQ_EN, 8'h00, 8'hFF);
    pulse(8'h16);
    chk(8'(irq_n), 8'h01);
    wr(CIR_OFS_IRQ_EN, 8'hFF, 8'hFF);
    chk(8'(code), 8'(CIR_CODE_TX0));
    // Held condition must survive a plain write of zero
    act = 8'h02;
    wr(CIR_OFS_IRQ_FLAGS, 8'h00, 8'hFF);
    chk(flg, 8'h02);
    rd(CIR_OFS_IRQ_FLAGS);
    chk(q, 8'h02);
    act = 8'h00;
    wr(CIR_OFS_IRQ_FLAGS, 8'h20, 8'hFF);
    chk(8'(code), 8'(CIR_CODE_ERR));
  endtask : t_mix
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    t_regs;
    t_each;
    t_mix;
    final_report;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count++;
      final_report;
    end
  end
endmodule : cir_irq_regs_tb
